// File: hw/cspc_defines.svh
// constants of the clock source, prescaler and pll control block
`ifndef CSPC_DEFINES_SVH
`define CSPC_DEFINES_SVH
// register indexes, byte address is four times the index
`define CSPC_IDX_PLL 8'h49
`define CSPC_IDX_DIV 8'h61
`define CSPC_IDX_SRC 8'h50
`define CSPC_IDX_CFG 8'h51
`define CSPC_IDX_STA 8'h52
`define CSPC_IDX_TRIM 8'h53
// reset values and field codes
`define CSPC_RC_CFG_RST 4'h2
`define CSPC_DIV8_CODE 4'h3
`define CSPC_DIV_MAX 4'h8
`define CSPC_UNLOCK_BIT 8'h80
`define CSPC_UNLOCK_CYC 3'h4
`define CSPC_RESP_OK 2'h0
`define CSPC_RESP_ERR 2'h2
// fuse vector layout
`define CSPC_F_EXT 15
`define CSPC_F_SUT 14:13
`define CSPC_F_SOURCE_FUSE 12:9
`define CSPC_F_DIV8 8
`define CSPC_F_TRIM 7:0
// timing
`define CSPC_CLK_MHZ 125
`define CSPC_PLL_LOCK_US 2000
`define CSPC_PLL_LOCK_CYC (`CSPC_PLL_LOCK_US * `CSPC_CLK_MHZ)
`endif

// File: hw/cspc_pkg.sv
// types of the clock source, prescaler and pll control block
package cspc_pkg;
	typedef enum logic [1:0] {CSPC_SS_RUN = 2'h1, CSPC_SS_ARM = 2'h2} cspc_sel_state_t;

	typedef struct packed {
		logic [1:0]      s1;
		logic [1:0]      s2;
		logic            cur;
		cspc_sel_state_t state;
		logic            out;
	} cspc_sel_st_t;

	typedef struct packed {
		logic       src_d;
		logic [3:0] code;
		logic [7:0] cnt;
		logic       out;
	} cspc_div_st_t;

	typedef struct packed {
		logic [1:0]  init_cnt;
		logic [15:0] fz1;
		logic [15:0] fz2;
		logic        aw_rdy;
		logic        w_rdy;
		logic        aw_got;
		logic        w_got;
		logic [7:0]  widx;
		logic [7:0]  wdat;
		logic        wlane;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        ar_rdy;
		logic        rvalid;
		logic [7:0]  rdata;
		logic [1:0]  rresp;
		logic [1:0]  rc_sut;
		logic [1:0]  ext_sut;
		logic [1:0]  ext_app;
		logic        rc_on;
		logic        ext_on;
		logic        pick;
		logic        rc_en;
		logic [3:0]  rc_cfg;
		logic [3:0]  ext_cfg;
		logic [7:0]  trim;
		logic        unlock;
		logic [2:0]  unl_cnt;
		logic [3:0]  div_sel;
		logic        pll_halve;
		logic        pll_on;
		logic        pll_lock;
		logic [19:0] lock_cnt;
		logic [1:0]  rdy1;
		logic [1:0]  rdy2;
		logic        ps1;
		logic        ps2;
		logic [1:0]  run;
		logic        sys_clk;
	} cspc_top_st_t;
endpackage

// File: hw/cspc_clk_if.sv
// clock path signals between control, source select and divider
`timescale 1ns/1ps
`default_nettype none
interface cspc_clk_if;
	logic       src_level;
	logic [3:0] div_sel;
	logic       div_level;
	modport sel_mp (output src_level);
	modport div_mp (input src_level, input div_sel, output div_level);
endinterface
`default_nettype wire

// File: hw/cspc_srcsel.sv
// glitch-free oscillator source select
`timescale 1ns/1ps
`default_nettype none
module cspc_srcsel (
	input  wire logic  clock_i,
	input  wire logic  rst_n_i,
	input  wire logic  rc_clk_i,
	input  wire logic  ext_clk_i,
	input  wire logic  pick_i,
	cspc_clk_if.sel_mp cif
);
	cspc_pkg::cspc_sel_st_t st;
	cspc_pkg::cspc_sel_st_t nx;
	logic                   old_l;
	logic                   new_l;

	assign cif.src_level = st.out;

	always_comb begin
		nx = st;
		nx.s1 = {ext_clk_i, rc_clk_i};
		nx.s2 = st.s1;
		old_l = st.s2[st.cur];
		new_l = st.s2[pick_i];
		case (st.state)
			cspc_pkg::CSPC_SS_RUN: begin
				if (pick_i != st.cur && !old_l) begin // see [RULE26]
					nx.state = cspc_pkg::CSPC_SS_ARM;
					nx.out = 1'b0;
				end else begin
					nx.out = old_l;
				end
			end
			cspc_pkg::CSPC_SS_ARM: begin
				nx.out = 1'b0;
				if (!new_l) begin // see [RULE26]
					nx.cur = pick_i;
					nx.state = cspc_pkg::CSPC_SS_RUN;
				end
			end
			default: begin
				nx.state = cspc_pkg::CSPC_SS_RUN;
				nx.out = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '{state: cspc_pkg::CSPC_SS_RUN, default: '0};
		end else begin
			st <= nx;
		end
	end

	switch_quiet_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see [RULE26]
		st.state == cspc_pkg::CSPC_SS_ARM |-> !st.out)
		else $error("output not held low during source switch");
endmodule
`default_nettype wire

// File: hw/cspc_clkdiv.sv
// glitch-free power-of-two system clock divider
`timescale 1ns/1ps
`default_nettype none
`include "cspc_defines.svh"
module cspc_clkdiv (
	input  wire logic  clock_i,
	input  wire logic  rst_n_i,
	cspc_clk_if.div_mp cif
);
	cspc_pkg::cspc_div_st_t st;
	cspc_pkg::cspc_div_st_t nx;
	logic [3:0]             n;
	logic [3:0]             pend;
	logic [3:0]             nn;
	logic [7:0]             mask;
	logic                   rise;
	logic                   wrap;

	// reserved codes divide as the largest legal code
	function automatic logic [3:0] eff(input logic [3:0] c);
		eff = (c > `CSPC_DIV_MAX) ? `CSPC_DIV_MAX : c; // see [RULE27]
	endfunction

	assign cif.div_level = st.out;

	always_comb begin
		nx = st;
		n = eff(st.code);
		pend = eff(cif.div_sel);
		mask = 8'((9'h001 << n) - 9'h001);
		rise = cif.src_level && !st.src_d;
		wrap = (n == 4'h0) || ((st.cnt & mask) == mask);
		nx.src_d = cif.src_level;
		if (rise) begin
			if (wrap && pend != n) begin // see [RULE25]
				nx.code = cif.div_sel;
				nx.cnt = 8'h00;
			end else begin
				nx.cnt = st.cnt + 8'h01;
			end
		end
		nn = eff(nx.code);
		nx.out = (nn == 4'h0) ? cif.src_level : nx.cnt[3'(nn - 4'h1)]; // see [RULE18]
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

	apply_edge_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see [RULE25]
		$changed(st.code) |-> $past(cif.src_level && !st.src_d) && (st.code == 4'h0 || !st.out))
		else $error("divider changed away from a period boundary");
endmodule
`default_nettype wire

// File: hw/cspc_top.sv
// clock source, prescaler and pll control with axi4-lite registers
//
// Notes on behaviour
// [RULE1] rc startup copy loaded once, read-only
// [RULE2] ext startup loaded from fuses, writable
// [RULE3] rc on bit enables rc oscillator
// [RULE4] ext on bit enables external oscillator
// [RULE5] source pick: one external, zero rc
// [RULE6] reset picks external when fuses say so
// [RULE7] software checks running flag before switching
// [RULE8] rc config resets to 0010, keep it
// [RULE9] ext config loads fuses, software may change
// [RULE10] running flags follow oscillator state
// [RULE11] reserved bits read zero
// [RULE12] trim loads factory value at reset
// [RULE13] trim top bit picks frequency range
// [RULE14] lower trim bits tune monotonically
// [RULE15] software avoids trim above 8.8 MHz
// [RULE16] unlock sets only on lone unlock write
// [RULE17] unlock clears after four cycles or write
// [RULE18] divider select divides by power of two
// [RULE19] divider resets to eight when fuse programmed
// [RULE20] any divider value accepted
// [RULE21] pll input halve sets prescaler
// [RULE22] pll on starts pll, enables rc when the pll source is rc
// [RULE23] pll lock sets after timer, clears off
// [RULE24] software unlocks then writes within four
// [RULE25] divider switches without short periods
// [RULE26] source switch without runt pulses
// [RULE27] reserved divider codes stored, largest division
`timescale 1ns/1ps
`default_nettype none
`include "cspc_defines.svh"
module cspc_top #(
	parameter int unsigned PLL_LOCK_CYC = `CSPC_PLL_LOCK_CYC
) (
	input  wire logic        clock_i,
	input  wire logic        rst_n_i,
	input  wire logic [11:0] s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [11:0] s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	input  wire logic        fuse_ext_sel_i,
	input  wire logic [1:0]  startup_fuse_i,
	input  wire logic [3:0]  source_fuse_i,
	input  wire logic        div8_fuse_i,
	input  wire logic [7:0]  trim_factory_i,
	input  wire logic        rc_ready_i,
	input  wire logic        ext_ready_i,
	input  wire logic        rc_clk_i,
	input  wire logic        ext_clk_i,
	input  wire logic        pll_src_rc_i,
	output logic             rc_en_o,
	output logic             ext_en_o,
	output logic [1:0]       ext_startup_o,
	output logic [3:0]       rc_cfg_o,
	output logic [3:0]       ext_cfg_o,
	output logic [7:0]       trim_o,
	output logic             pll_en_o,
	output logic             pll_halve_o,
	output logic             sys_clk_o
);
	localparam logic [19:0] LOCK_LAST = 20'(PLL_LOCK_CYC - 1);
	localparam cspc_pkg::cspc_top_st_t RST_ST = '{rc_cfg: `CSPC_RC_CFG_RST, default: '0};

	cspc_pkg::cspc_top_st_t st;
	cspc_pkg::cspc_top_st_t nx;
	logic                   wr_fire;
	logic                   rd_take;
	logic [7:0]             ra_idx;
	logic                   ext_fz;

	// ----------------------------------------------------------------
	// address map
	// ----------------------------------------------------------------
	function automatic logic map_ok(input logic [7:0] idx);
		map_ok = (idx == `CSPC_IDX_PLL) || (idx == `CSPC_IDX_DIV) ||
			(idx == `CSPC_IDX_SRC) || (idx == `CSPC_IDX_CFG) ||
			(idx == `CSPC_IDX_STA) || (idx == `CSPC_IDX_TRIM);
	endfunction

	// ----------------------------------------------------------------
	// clock path
	// ----------------------------------------------------------------
	cspc_clk_if cif ();

	assign cif.div_sel = st.div_sel;

	cspc_srcsel u_sel (
		.clock_i   (clock_i),
		.rst_n_i   (rst_n_i),
		.rc_clk_i  (rc_clk_i),
		.ext_clk_i (ext_clk_i),
		.pick_i    (st.pick),
		.cif       (cif)
	);

	cspc_clkdiv u_div (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.cif     (cif)
	);

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign s_axi_awready_o = st.aw_rdy;
	assign s_axi_wready_o  = st.w_rdy;
	assign s_axi_bresp_o   = st.bresp;
	assign s_axi_bvalid_o  = st.bvalid;
	assign s_axi_arready_o = st.ar_rdy;
	assign s_axi_rdata_o   = {24'h000000, st.rdata};
	assign s_axi_rresp_o   = st.rresp;
	assign s_axi_rvalid_o  = st.rvalid;
	assign rc_en_o         = st.rc_en;
	assign ext_en_o        = st.ext_on;
	assign ext_startup_o   = st.ext_app;
	assign rc_cfg_o        = st.rc_cfg;
	assign ext_cfg_o       = st.ext_cfg;
	assign trim_o          = st.trim; // see [RULE13] see [RULE14]
	assign pll_en_o        = st.pll_on;
	assign pll_halve_o     = st.pll_halve;
	assign sys_clk_o       = st.sys_clk;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		nx = st;
		wr_fire = 1'b0;
		rd_take = s_axi_arvalid_i && st.ar_rdy;
		ra_idx = s_axi_araddr_i[9:2];
		ext_fz = st.fz2[`CSPC_F_EXT];
		// pin synchronisers
		nx.fz1 = {fuse_ext_sel_i, startup_fuse_i, source_fuse_i, div8_fuse_i, trim_factory_i};
		nx.fz2 = st.fz1;
		nx.rdy1 = {rc_ready_i, ext_ready_i};
		nx.rdy2 = st.rdy1;
		nx.ps1 = pll_src_rc_i;
		nx.ps2 = st.ps1;
		nx.sys_clk = cif.div_level;
		// fuse load once the synchronised straps are settled
		if (st.init_cnt != 2'h3) begin
			nx.init_cnt = st.init_cnt + 2'h1;
		end
		if (st.init_cnt == 2'h2) begin
			nx.pick = ext_fz; // see [RULE6]
			nx.ext_on = ext_fz;
			nx.rc_on = !ext_fz;
			nx.rc_sut = ext_fz ? 2'h0 : st.fz2[`CSPC_F_SUT]; // see [RULE1]
			nx.ext_sut = ext_fz ? st.fz2[`CSPC_F_SUT] : 2'h0; // see [RULE2]
			nx.ext_app = nx.ext_sut;
			nx.ext_cfg = ext_fz ? st.fz2[`CSPC_F_SOURCE_FUSE] : 4'h0; // see [RULE9]
			nx.rc_cfg = `CSPC_RC_CFG_RST; // see [RULE8]
			nx.trim = st.fz2[`CSPC_F_TRIM]; // see [RULE12]
			nx.div_sel = st.fz2[`CSPC_F_DIV8] ? `CSPC_DIV8_CODE : 4'h0; // see [RULE19]
			nx.aw_rdy = 1'b1;
			nx.w_rdy = 1'b1;
			nx.ar_rdy = 1'b1;
		end
		// unlock window countdown
		if (st.unlock) begin
			if (st.unl_cnt == 3'h1) begin
				nx.unlock = 1'b0; // see [RULE17]
			end
			nx.unl_cnt = st.unl_cnt - 3'h1;
		end
		// pll lock timer
		if (!st.pll_on) begin
			nx.lock_cnt = 20'h00000;
			nx.pll_lock = 1'b0; // see [RULE23]
		end else if (st.lock_cnt == LOCK_LAST) begin
			nx.pll_lock = 1'b1; // see [RULE23]
		end else begin
			nx.lock_cnt = st.lock_cnt + 20'h00001;
		end
		// write address and data, taken in either order
		if (s_axi_awvalid_i && st.aw_rdy) begin
			nx.aw_rdy = 1'b0;
			nx.aw_got = 1'b1;
			nx.widx = s_axi_awaddr_i[9:2];
		end
		if (s_axi_wvalid_i && st.w_rdy) begin
			nx.w_rdy = 1'b0;
			nx.w_got = 1'b1;
			nx.wdat = s_axi_wdata_i[7:0];
			nx.wlane = s_axi_wstrb_i[0];
		end
		if (st.aw_got && st.w_got && !st.bvalid) begin
			wr_fire = 1'b1;
			nx.aw_got = 1'b0;
			nx.w_got = 1'b0;
			nx.bvalid = 1'b1;
			nx.bresp = map_ok(st.widx) ? `CSPC_RESP_OK : `CSPC_RESP_ERR;
			if (st.wlane) begin
				if (st.widx == `CSPC_IDX_SRC) begin
					nx.ext_sut = st.wdat[5:4]; // see [RULE2]
					nx.rc_on = st.wdat[3]; // see [RULE3]
					nx.ext_on = st.wdat[2]; // see [RULE4]
					nx.pick = st.wdat[0]; // see [RULE5]
				end else if (st.widx == `CSPC_IDX_CFG) begin
					nx.rc_cfg = st.wdat[7:4]; // see [RULE8]
					nx.ext_cfg = st.wdat[3:0]; // see [RULE9]
				end else if (st.widx == `CSPC_IDX_TRIM) begin
					nx.trim = st.wdat; // see [RULE12]
				end else if (st.widx == `CSPC_IDX_DIV) begin
					if (st.wdat == `CSPC_UNLOCK_BIT) begin
						if (!st.unlock) begin // see [RULE16]
							nx.unlock = 1'b1;
							nx.unl_cnt = `CSPC_UNLOCK_CYC;
						end
					end else if (st.unlock && !st.wdat[7]) begin
						nx.div_sel = st.wdat[3:0]; // see [RULE20] see [RULE27]
						nx.unlock = 1'b0; // see [RULE17]
					end
				end else if (st.widx == `CSPC_IDX_PLL) begin
					nx.pll_halve = st.wdat[2]; // see [RULE21]
					nx.pll_on = st.wdat[1]; // see [RULE22]
				end
			end
		end
		if (st.bvalid && s_axi_bready_i) begin
			nx.bvalid = 1'b0;
			nx.aw_rdy = 1'b1;
			nx.w_rdy = 1'b1;
		end
		// external startup value takes effect at each start
		if (!st.ext_on && nx.ext_on) begin
			nx.ext_app = nx.ext_sut; // see [RULE2]
		end
		nx.rc_en = nx.rc_on | (nx.pll_on & st.ps2); // see [RULE22] see [RULE3]
		nx.run = st.rdy2 & {st.rc_en, st.ext_on}; // see [RULE10]
		// read channel
		if (rd_take) begin
			nx.ar_rdy = 1'b0;
			nx.rvalid = 1'b1;
			nx.rresp = map_ok(ra_idx) ? `CSPC_RESP_OK : `CSPC_RESP_ERR;
			if (ra_idx == `CSPC_IDX_SRC) begin
				nx.rdata = {st.rc_sut, st.ext_sut, st.rc_on, st.ext_on, 1'b0, st.pick};
			end else if (ra_idx == `CSPC_IDX_CFG) begin
				nx.rdata = {st.rc_cfg, st.ext_cfg};
			end else if (ra_idx == `CSPC_IDX_STA) begin
				nx.rdata = {6'h00, st.run}; // see [RULE11] see [RULE10]
			end else if (ra_idx == `CSPC_IDX_TRIM) begin
				nx.rdata = st.trim;
			end else if (ra_idx == `CSPC_IDX_DIV) begin
				nx.rdata = {st.unlock, 3'h0, st.div_sel}; // see [RULE11]
			end else if (ra_idx == `CSPC_IDX_PLL) begin
				nx.rdata = {5'h00, st.pll_halve, st.pll_on, st.pll_lock}; // see [RULE11]
			end else begin
				nx.rdata = 8'h00;
			end
		end
		if (st.rvalid && s_axi_rready_i) begin
			nx.rvalid = 1'b0;
			nx.ar_rdy = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= RST_ST;
		end else begin
			st <= nx;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);

	unlock_timeout_a: assert property ( // see [RULE17]
		$rose(st.unlock) |-> ##4 !st.unlock)
		else $error("unlock window longer than four cycles");

	unlock_cause_a: assert property ( // see [RULE16]
		$rose(st.unlock) |-> $past(wr_fire && st.wlane && st.widx == 8'h61 && st.wdat == 8'h80))
		else $error("unlock set without a lone unlock write");

	div_guard_a: assert property ( // see [RULE17]
		st.init_cnt == 2'h3 && $past(st.init_cnt) == 2'h3 && $changed(st.div_sel)
			|-> $past(st.unlock) && !st.unlock)
		else $error("divider changed outside the unlock window");

	sut_frozen_a: assert property ( // see [RULE1]
		st.init_cnt == 2'h3 && $past(st.init_cnt) == 2'h3 |-> $stable(st.rc_sut))
		else $error("rc startup copy changed after reset");

	fuse_load_a: assert property ( // see [RULE19]
		st.init_cnt == 2'h2 |=> st.pick == $past(st.fz2[15]) &&
			st.div_sel == ($past(st.fz2[8]) ? 4'h3 : 4'h0) && st.rc_cfg == 4'h2)
		else $error("reset values not loaded from fuses");

	sta_read_a: assert property ( // see [RULE11]
		rd_take && ra_idx == 8'h52 |=> st.rvalid && st.rdata == {6'h00, $past(st.run)})
		else $error("status read shows wrong bits");

	pll_clear_a: assert property ( // see [RULE23]
		!st.pll_on |=> !st.pll_lock)
		else $error("pll lock flag stays without pll on");

	pll_lock_a: assert property ( // see [RULE23]
		$rose(st.pll_lock) |-> st.pll_on && $past(st.pll_on, 2))
		else $error("pll lock flag set too early");

	rc_auto_a: assert property ( // see [RULE22]
		st.pll_on && $past(st.ps2) |-> st.rc_en)
		else $error("rc oscillator not enabled for pll");

	run_flag_a: assert property ( // see [RULE10]
		st.run[0] |-> $past(st.rdy2[0] && st.ext_on))
		else $error("external running flag without a running oscillator");

	src_write_a: assert property ( // see [RULE5]
		wr_fire && st.wlane && st.widx == 8'h50 && st.init_cnt == 2'h3
			|=> st.rc_on == $past(st.wdat[3]) && st.pick == $past(st.wdat[0]))
		else $error("source control write not applied");
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench of the clock control block
`timescale 1ns/1ps
`default_nettype none
`include "cspc_defines.svh"
module tb_top;
	logic        clock_i, rst_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
	logic        s_axi_arvalid_i, s_axi_rready_i, fuse_ext_sel_i, div8_fuse_i;
	logic        rc_ready_i, ext_ready_i, rc_clk_i, ext_clk_i, pll_src_rc_i;
	logic [11:0] s_axi_awaddr_i, s_axi_araddr_i;
	logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
	logic [3:0]  s_axi_wstrb_i, source_fuse_i, rc_cfg_o, ext_cfg_o;
	logic [1:0]  startup_fuse_i, s_axi_bresp_o, s_axi_rresp_o, ext_startup_o;
	logic [7:0]  trim_factory_i, trim_o;
	logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
	logic        s_axi_rvalid_o, rc_en_o, ext_en_o, pll_en_o, pll_halve_o, sys_clk_o;
	int          num_errors, cmp_count, cycles, ph_rc, ph_ext;
	logic [1:0]  rsp;
	logic [31:0] rdat;
	int          n;

	cspc_top #(.PLL_LOCK_CYC(16)) dut (.clock_i, .rst_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
		.s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
		.s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
		.s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
		.fuse_ext_sel_i, .startup_fuse_i, .source_fuse_i, .div8_fuse_i, .trim_factory_i,
		.rc_ready_i, .ext_ready_i, .rc_clk_i, .ext_clk_i, .pll_src_rc_i, .rc_en_o, .ext_en_o,
		.ext_startup_o, .rc_cfg_o, .ext_cfg_o, .trim_o, .pll_en_o, .pll_halve_o, .sys_clk_o);

	// ------------------------------------------------------------
	// clock, oscillators and timeout
	// ------------------------------------------------------------
	always #4 clock_i = ~clock_i;
	always @(posedge clock_i) begin
		ph_rc <= (ph_rc + 1) % 8;
		ph_ext <= (ph_ext + 1) % 12;
		if (ph_rc == 7) rc_clk_i <= ~rc_clk_i;
		if (ph_ext == 11) ext_clk_i <= ~ext_clk_i;
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			num_errors++;
			wrap_up();
		end
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] dat, output logic [1:0] resp);
		s_axi_awaddr_i <= {2'b00, idx, 2'b00};
		s_axi_wdata_i <= {24'h000000, dat};
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		do begin
			@(posedge clock_i);
			if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
		end while (s_axi_bvalid_o !== 1'b1);
		resp = s_axi_bresp_o;
	endtask
	task automatic rd(input logic [7:0] idx, output logic [31:0] dat, output logic [1:0] resp);
		s_axi_araddr_i <= {2'b00, idx, 2'b00};
		s_axi_arvalid_i <= 1'b1;
		do begin
			@(posedge clock_i);
			if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
		end while (s_axi_rvalid_o !== 1'b1);
		dat = s_axi_rdata_o;
		resp = s_axi_rresp_o;
	endtask
	task automatic wrok(input logic [7:0] idx, input logic [7:0] dat);
		wr(idx, dat, rsp);
		check("bresp", {30'h0, `CSPC_RESP_OK}, {30'h0, rsp});
	endtask
	task automatic rdchk(input string nm, input logic [7:0] idx, input logic [7:0] exp);
		rd(idx, rdat, rsp);
		check(nm, {24'h000000, exp}, rdat);
		check("rresp", {30'h0, `CSPC_RESP_OK}, {30'h0, rsp});
	endtask
	task automatic do_reset(input logic ext, input logic d8, input logic [7:0] trim);
		rst_n_i <= 1'b0;
		fuse_ext_sel_i <= ext;
		div8_fuse_i <= d8;
		trim_factory_i <= trim;
		repeat (16) @(posedge clock_i);
		rst_n_i <= 1'b1;
		repeat (5) @(posedge clock_i);
	endtask
	task automatic count_edges(output int cnt);
		logic prev;
		cnt = 0;
		prev = sys_clk_o;
		repeat (640) begin
			@(posedge clock_i);
			if (sys_clk_o === 1'b1 && prev === 1'b0) cnt++;
			prev = sys_clk_o;
		end
	endtask
	task automatic unlock_set(input logic [7:0] code);
		wrok(`CSPC_IDX_DIV, `CSPC_UNLOCK_BIT);
		wrok(`CSPC_IDX_DIV, code);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset_rc;
		do_reset(1'b0, 1'b1, 8'hA5);
		rdchk("src", `CSPC_IDX_SRC, 8'h48);
		rdchk("cfg", `CSPC_IDX_CFG, 8'h20);
		rdchk("trim", `CSPC_IDX_TRIM, 8'hA5);
		rdchk("div", `CSPC_IDX_DIV, 8'h03);
		rdchk("pll", `CSPC_IDX_PLL, 8'h00);
		rdchk("sta", `CSPC_IDX_STA, 8'h02);
		check("rc_cfg_o", 32'h2, {28'h0, rc_cfg_o});
		$display("done reset_rc");
	endtask
	task automatic t_src;
		wrok(`CSPC_IDX_SRC, 8'h3C);
		check("ext_en", 32'h1, {31'h0, ext_en_o});
		check("ext_sut", 32'h3, {30'h0, ext_startup_o});
		repeat (8) @(posedge clock_i);
		rdchk("sta", `CSPC_IDX_STA, 8'h03);
		wrok(`CSPC_IDX_SRC, 8'hDF);
		rdchk("src", `CSPC_IDX_SRC, 8'h5D);
		check("ext_sut", 32'h3, {30'h0, ext_startup_o});
		wrok(`CSPC_IDX_SRC, 8'h00);
		rdchk("src", `CSPC_IDX_SRC, 8'h40);
		check("rc_en", 32'h0, {31'h0, rc_en_o});
		repeat (8) @(posedge clock_i);
		rdchk("sta", `CSPC_IDX_STA, 8'h00);
		$display("done src");
	endtask
	task automatic t_cfg;
		wrok(`CSPC_IDX_CFG, 8'h2A);
		rdchk("cfg", `CSPC_IDX_CFG, 8'h2A);
		check("ext_cfg", 32'hA, {28'h0, ext_cfg_o});
		wrok(`CSPC_IDX_TRIM, 8'h7F);
		rdchk("trim", `CSPC_IDX_TRIM, 8'h7F);
		check("trim_o", 32'h7F, {24'h0, trim_o});
		$display("done cfg");
	endtask
	task automatic t_div;
		unlock_set(8'h05);
		rdchk("div", `CSPC_IDX_DIV, 8'h05);
		wrok(`CSPC_IDX_DIV, 8'h06);
		rdchk("div", `CSPC_IDX_DIV, 8'h05);
		unlock_set(8'h81);
		wrok(`CSPC_IDX_DIV, 8'h07);
		rdchk("div", `CSPC_IDX_DIV, 8'h05);
		wrok(`CSPC_IDX_DIV, `CSPC_UNLOCK_BIT);
		repeat (8) @(posedge clock_i);
		wrok(`CSPC_IDX_DIV, 8'h07);
		rdchk("div", `CSPC_IDX_DIV, 8'h05);
		wrok(`CSPC_IDX_DIV, `CSPC_UNLOCK_BIT);
		unlock_set(8'h07);
		rdchk("div", `CSPC_IDX_DIV, 8'h05);
		unlock_set(8'h0F);
		rdchk("div", `CSPC_IDX_DIV, 8'h0F);
		$display("done div");
	endtask
	task automatic t_rate;
		wrok(`CSPC_IDX_SRC, 8'h0C);
		unlock_set(8'h00);
		// the old setting may divide by 256, so its last period must run out first
		repeat (4200) @(posedge clock_i);
		count_edges(n);
		check("rc_div1", 32'h1, {31'h0, (n >= 39 && n <= 41)});
		unlock_set(8'h02);
		repeat (200) @(posedge clock_i);
		count_edges(n);
		check("rc_div4", 32'h1, {31'h0, (n >= 9 && n <= 11)});
		unlock_set(8'h00);
		rdchk("sta", `CSPC_IDX_STA, 8'h03);
		wrok(`CSPC_IDX_SRC, 8'h0D);
		repeat (200) @(posedge clock_i);
		count_edges(n);
		check("ext_div1", 32'h1, {31'h0, (n >= 25 && n <= 28)});
		$display("done rate");
	endtask
	task automatic t_pll;
		wrok(`CSPC_IDX_SRC, 8'h00);
		wrok(`CSPC_IDX_PLL, 8'h04);
		wrok(`CSPC_IDX_PLL, 8'hFF);
		check("pll_en", 32'h1, {31'h0, pll_en_o});
		check("pll_halve", 32'h1, {31'h0, pll_halve_o});
		check("rc_en", 32'h1, {31'h0, rc_en_o});
		rdchk("pll", `CSPC_IDX_PLL, 8'h06);
		repeat (20) @(posedge clock_i);
		rdchk("pll", `CSPC_IDX_PLL, 8'h07);
		wrok(`CSPC_IDX_PLL, 8'h04);
		rdchk("pll", `CSPC_IDX_PLL, 8'h04);
		check("rc_en", 32'h0, {31'h0, rc_en_o});
		wr(8'h10, 8'h55, rsp);
		check("bresp_bad", {30'h0, `CSPC_RESP_ERR}, {30'h0, rsp});
		rd(8'h10, rdat, rsp);
		check("rresp_bad", {30'h0, `CSPC_RESP_ERR}, {30'h0, rsp});
		check("rdata_bad", 32'h0, rdat);
		$display("done pll");
	endtask
	task automatic t_reset_ext;
		do_reset(1'b1, 1'b0, 8'h3C);
		rdchk("src", `CSPC_IDX_SRC, 8'h15);
		rdchk("cfg", `CSPC_IDX_CFG, 8'h27);
		rdchk("div", `CSPC_IDX_DIV, 8'h00);
		rdchk("trim", `CSPC_IDX_TRIM, 8'h3C);
		$display("done reset_ext");
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		clock_i = 1'b0;
		rst_n_i = 1'b0;
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_arvalid_i} = 3'h0;
		{s_axi_bready_i, s_axi_rready_i, rc_ready_i, ext_ready_i, pll_src_rc_i} = 5'h1F;
		{rc_clk_i, ext_clk_i, fuse_ext_sel_i, div8_fuse_i} = 4'h0;
		s_axi_awaddr_i = 12'h000;
		s_axi_araddr_i = 12'h000;
		s_axi_wdata_i = 32'h00000000;
		s_axi_wstrb_i = 4'h1;
		startup_fuse_i = 2'h1;
		source_fuse_i = 4'h7;
		trim_factory_i = 8'h00;
		{num_errors, cmp_count, cycles, ph_rc, ph_ext} = '0;
		@(posedge clock_i);
		t_reset_rc();
		t_src();
		t_cfg();
		t_div();
		t_rate();
		t_pll();
		t_reset_ext();
		wrap_up();
	end
endmodule
`default_nettype wire
